// ==== rtl/rss_reset_source_sequencer.sv ====
// Top of the reset source sequencer: source merge, pin drive, release timing.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer
#(
   parameter int PIN_LONG_CYC = 4163 // Low pin cycles for flag after power reset.
)
(
   input wire logic ref_clk, // System clock.
   input wire logic reset, // Asynchronous reset, treated as power-on.
   input wire logic osc_ref_clock, // Oscillator reference clock level.
   input wire logic por_pulse, // Power-on pulse.
   input wire logic reset_pin_in, // Reset pin level, low is reset.
   output logic reset_pin_out, // Reset pin drive value, always low.
   output logic reset_pin_oe, // High while pulling the pin low.
   input wire logic watchdog_overflow, // Watchdog overflow, asynchronous.
   input wire logic watchdog_disable_opt, // Watchdog disabled.
   input wire logic low_voltage_det, // Low-voltage detector output.
   input wire logic undervoltage_power_dis, // Low-voltage power down disable.
   input wire logic undervoltage_reset_dis, // Low-voltage reset disable.
   input wire logic op_fetch, // Opcode fetch strobe.
   input wire logic [7:0] op_byte, // Fetched opcode byte.
   input wire logic fetch_unmapped, // Address is unmapped.
   input wire logic cpu_illegal, // CPU illegal instruction decode.
   input wire logic stop_enable_opt, // Stop instruction allowed.
   input wire logic short_wake_delay_opt, // Short stop recovery delay.
   input wire logic wake_event, // Interrupt or break ends stop.
   input wire logic monitor_mode, // Monitor mode selects vector.
   output logic internal_reset_signal, // Internal reset, active high.
   output logic [15:0] reset_vector, // Reset vector address.
   output logic [7:0] reset_cause_register, // Reset cause flags.
   output logic core_source_clock_en, // Core source clock enable.
   output logic cpu_clock_en, // CPU and module clock enable.
   output logic watchdog_clk // Watchdog advance pulse.
);
   import rss_pkg::*;

   // ****************************************
   // Oscillator edge and watchdog crossing
   // ****************************************
   logic osc_prev_q, osc_tick;
   logic wd_s1_q, wd_s2_q, wd_s3_q, wd_rise;

   // Sample oscillator level and pass the watchdog request through three flops.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         osc_prev_q <= 1'b0;
         wd_s1_q <= 1'b0;
         wd_s2_q <= 1'b0;
         wd_s3_q <= 1'b0;
      end
      else
      begin
         osc_prev_q <= osc_ref_clock;
         wd_s1_q <= watchdog_overflow; // RULE9
         wd_s2_q <= wd_s1_q;
         wd_s3_q <= wd_s2_q;
      end
   end

   // Falling oscillator edge and rising synchronised watchdog request.
   assign osc_tick = osc_prev_q && !osc_ref_clock; // RULE19
   assign wd_rise = wd_s2_q && !wd_s3_q;

   // ****************************************
   // Submodules
   // ****************************************
   rss_cnt_if cnt ();
   logic bad_opc, bad_adr, stop_go;
   logic internal_reset_signal_q;

   rss_stab_counter u_cnt
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .c(cnt.cnt)
   );

   rss_opcode_check u_chk
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .flush(internal_reset_signal_q),
      .op_fetch(op_fetch),
      .op_byte(op_byte),
      .fetch_unmapped(fetch_unmapped),
      .cpu_illegal(cpu_illegal),
      .stop_enable_opt(stop_enable_opt),
      .bad_opc(bad_opc),
      .bad_adr(bad_adr),
      .stop_go(stop_go)
   );

   // ****************************************
   // Source merge and sequence
   // ****************************************
   rss_st_e st_q, st_d;
   logic [SEQ_W-1:0] seq_q, seq_d;
   logic [PIN_W-1:0] pin_cnt_q, pin_cnt_d;
   logic [7:0] cause_q, cause_d;
   logic pwr_q, pwr_d;
   logic oe_q, oe_d, internal_reset_signal_d, core_q, core_d, cpu_q, cpu_d, wdc_q, wdc_d;
   logic [15:0] vec_q, vec_d;
   logic pin_q;
   logic cnt_clr, lv_evt, wd_evt, accept, pin_low, pin_hit, wake_done;
   logic [PIN_W-1:0] pin_need;

   // Qualified events and helpers.
   always_comb
   begin
      lv_evt = low_voltage_det && !undervoltage_power_dis && !undervoltage_reset_dis; // RULE18
      wd_evt = wd_rise && !watchdog_disable_opt; // RULE13
      accept = (st_q == ST_RUN) || (st_q == ST_STOP) || (st_q == ST_WAKE);
      pin_low = !reset_pin_in && !oe_q; // RULE5
      pin_need = pwr_q ? PIN_W'(PIN_LONG_CYC) : PIN_SHORT; // RULE6
      pin_hit = (pin_cnt_q >= pin_need);
      if (short_wake_delay_opt)
         wake_done = osc_tick && (cnt.value == WAKE_SHORT_LAST); // RULE21
      else
         wake_done = cnt.ovf;
   end

   // Next state, counter clear and cause flags.
   always_comb
   begin
      st_d = st_q;
      seq_d = seq_q;
      pwr_d = pwr_q;
      cnt_clr = 1'b0;
      cause_d = cause_q;
      if (pin_hit)
         cause_d[C_PIN] = 1'b1; // RULE4 RULE5
      case (st_q)
         ST_RUN:
         begin
            if (pin_low)
               st_d = ST_EXT; // RULE5
            else if (stop_go)
               st_d = ST_STOP;
         end
         ST_STOP:
         begin
            cnt_clr = 1'b1; // RULE21
            if (pin_low)
               st_d = ST_EXT;
            else if (wake_event)
               st_d = ST_WAKE;
         end
         ST_WAKE:
         begin
            if (pin_low)
               st_d = ST_EXT;
            else if (wake_done)
               st_d = ST_RUN; // RULE21
         end
         ST_EXT:
         begin
            if (!pin_low)
            begin
               st_d = ST_HOLD;
               seq_d = '0;
            end
         end
         ST_PWR:
         begin
            cnt_clr = low_voltage_det; // RULE18
            if (cnt.ovf)
            begin
               st_d = ST_DRIVE; // RULE8 RULE10
               seq_d = '0;
            end
         end
         ST_DRIVE:
         begin
            if (osc_tick)
            begin
               seq_d = seq_q + 6'h01;
               if (seq_q == DRIVE_LAST)
               begin
                  st_d = ST_HOLD; // RULE7
                  seq_d = '0;
               end
            end
         end
         ST_HOLD:
         begin
            if (osc_tick)
            begin
               seq_d = seq_q + 6'h01;
               if (seq_q == HOLD_LAST)
               begin
                  st_d = ST_RUN; // RULE7 RULE22
                  pwr_d = 1'b0;
               end
            end
         end
         default:
            st_d = ST_RUN;
      endcase
      if (accept && (wd_evt || bad_adr || bad_opc))
      begin
         st_d = ST_DRIVE; // RULE7
         seq_d = '0;
         cnt_clr = 1'b1; // RULE3
         cause_d[C_WD] = cause_q[C_WD] || wd_evt; // RULE13
         cause_d[C_ADR] = cause_q[C_ADR] || bad_adr; // RULE17
         cause_d[C_OPC] = cause_q[C_OPC] || bad_opc; // RULE14
      end
      if (lv_evt)
      begin
         st_d = ST_PWR; // RULE18
         cnt_clr = 1'b1;
         pwr_d = 1'b1;
         cause_d[C_LV] = 1'b1; // RULE4
      end
      if (por_pulse)
      begin
         st_d = ST_PWR; // RULE11
         cnt_clr = 1'b1;
         pwr_d = 1'b1;
         cause_d = CAUSE_POR_VAL; // RULE12
      end
   end

   // Low pin length counter, saturating.
   always_comb
   begin
      pin_cnt_d = pin_cnt_q;
      if (reset_pin_in)
         pin_cnt_d = '0;
      else if (osc_tick && (pin_cnt_q != PIN_MAX))
         pin_cnt_d = pin_cnt_q + 13'h0001;
   end

   // Output values derived from the next state; watchdog pulse from counter overflow.
   always_comb
   begin
      oe_d = (st_d == ST_PWR) || (st_d == ST_DRIVE); // RULE7 RULE8
      internal_reset_signal_d = oe_d || (st_d == ST_HOLD) || (st_d == ST_EXT); // RULE1 RULE2
      core_d = (st_d != ST_STOP); // RULE11
      cpu_d = !((st_d == ST_PWR) || (st_d == ST_STOP) || (st_d == ST_WAKE)); // RULE11
      vec_d = vec_q;
      if (internal_reset_signal_d)
         vec_d = monitor_mode ? VEC_MON : VEC_NORM; // RULE1
      wdc_d = cnt.ovf; // RULE20
   end

   assign cnt.tick = osc_tick;
   assign cnt.clr = cnt_clr;

   // State and output registers; reset acts as a power-on.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         st_q <= ST_PWR;
         seq_q <= '0;
         pin_cnt_q <= '0;
         cause_q <= CAUSE_POR_VAL;
         pwr_q <= 1'b1;
         oe_q <= 1'b1;
         internal_reset_signal_q <= 1'b1;
         core_q <= 1'b1;
         cpu_q <= 1'b0;
         vec_q <= VEC_NORM;
         wdc_q <= 1'b0;
         pin_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         seq_q <= seq_d;
         pin_cnt_q <= pin_cnt_d;
         cause_q <= cause_d;
         pwr_q <= pwr_d;
         oe_q <= oe_d;
         internal_reset_signal_q <= internal_reset_signal_d;
         core_q <= core_d;
         cpu_q <= cpu_d;
         vec_q <= vec_d;
         wdc_q <= wdc_d;
         pin_q <= 1'b0;
      end
   end

   assign reset_pin_out = pin_q;
   assign reset_pin_oe = oe_q;
   assign internal_reset_signal = internal_reset_signal_q;
   assign reset_vector = vec_q;
   assign reset_cause_register = cause_q;
   assign core_source_clock_en = core_q;
   assign cpu_clock_en = cpu_q;
   assign watchdog_clk = wdc_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   AST_VECTOR: assert property (internal_reset_signal_q && $past(internal_reset_signal_d) |-> // RULE1
      vec_q == ($past(monitor_mode) ? VEC_MON : VEC_NORM))
      else $error("Reset vector does not match mode.");
   AST_POR_CAUSE: assert property (por_pulse |=> cause_q == CAUSE_POR_VAL) // RULE12
      else $error("Power-on did not set only its own flag.");
   AST_WD_FLAG: assert property (accept && wd_evt && !lv_evt && !por_pulse |=> // RULE13
      cause_q[C_WD] && st_q == ST_DRIVE)
      else $error("Watchdog reset not taken.");
   AST_DRIVE: assert property (st_q == ST_DRIVE |-> oe_q && internal_reset_signal_q) // RULE7
      else $error("Pin not driven during drive phase.");
   AST_HOLD: assert property (st_q == ST_HOLD |-> !oe_q && internal_reset_signal_q && cpu_q) // RULE7
      else $error("Hold phase outputs wrong.");
   AST_EXT_KEEP: assert property (st_q == ST_EXT && !lv_evt && !por_pulse |-> !cnt_clr) // RULE3
      else $error("External reset disturbed the counter.");
   AST_STOP_CLR: assert property (st_q == ST_STOP && $past(st_q) == ST_STOP |-> cnt.value == '0) // RULE21
      else $error("Counter not held clear in stop.");
   AST_LV_HOLD: assert property (st_q == ST_PWR && low_voltage_det |-> cnt_clr ##1 oe_q) // RULE18
      else $error("Low voltage wait not held.");
   AST_PIN_FLAG: assert property ($rose(cause_q[C_PIN]) |-> $past(pin_hit)) // RULE5
      else $error("Pin flag set too early.");
   AST_WD_CLK: assert property (cnt.ovf |=> watchdog_clk) // RULE20
      else $error("Overflow did not advance watchdog.");
   AST_PWR_CPU: assert property (st_q == ST_PWR |-> !cpu_q && core_q) // RULE11
      else $error("Clocks wrong during stabilization.");
   AST_INT_CLR: assert property (accept && (wd_evt || bad_adr || bad_opc) |=> // RULE3
      cnt.value == '0)
      else $error("Internal reset left the counter running.");
   AST_RELEASE: assert property (st_q == ST_HOLD && osc_tick && seq_q == HOLD_LAST && // RULE7
      !lv_evt && !por_pulse |=> !internal_reset_signal_q)
      else $error("Internal reset not released after hold.");
   AST_PIN_LOW: assert property (reset_pin_oe |-> // RULE7
      !reset_pin_out)
      else $error("Pin driven high.");
   AST_RUN_QUIET: assert property (st_q == ST_RUN && !lv_evt && !por_pulse && // RULE18
      !pin_low && !wd_evt && !bad_adr && !bad_opc |=> !internal_reset_signal_q)
      else $error("Reset taken without an enabled source.");

   COV_POR_DONE: cover property (st_q == ST_HOLD ##1 st_q == ST_RUN);
   COV_EXT: cover property (st_q == ST_EXT ##1 st_q == ST_HOLD);
   COV_WAKE: cover property (st_q == ST_WAKE ##1 st_q == ST_RUN);
   COV_WD: cover property (accept && wd_evt);
   COV_LV: cover property (st_q == ST_RUN && lv_evt);
endmodule
`default_nettype wire

// ==== rtl/rss_pkg.sv ====
// Constants, states and cause bit layout of the reset source sequencer.
// Summary of operation
// RULE1: Every reset asserts internal reset and selects the normal or monitor reset vector.
// RULE2: While internal reset is asserted, registers and modules return to reset state.
// RULE3: Internal resets clear the stabilization counter; external pin reset leaves it alone.
// RULE4: Each reset source sets its own cause flag.
// RULE5: Low pin halts processing; pin flag needs 67 low cycles for ordinary resets.
// RULE6: After power-on or low-voltage reset the pin flag needs 4163 low cycles.
// RULE7: Internal resets drive the pin low 32 cycles, then hold internal reset 32 more.
// RULE8: Power-on and low-voltage resets first count 4096 cycles with the pin low.
// RULE9: The watchdog request is taken asynchronously and synchronised before use.
// RULE10: After power-on, pin low 4096 cycles, then release 64 cycles later.
// RULE11: Power-on asserts reset, enables core clock, stops CPU clocks during stabilization.
// RULE12: Power-on sets the power-on flag and clears all other cause flags.
// RULE13: Watchdog overflow resets and sets its flag only while watchdog is enabled.
// RULE14: Illegal instructions set the bad opcode flag and generate a reset.
// RULE15: Prefix byte 9E followed by stop opcode 8E yields an illegal opcode reset.
// RULE16: With stop disabled, a stop opcode gives an illegal opcode reset.
// RULE17: Opcode fetch from unmapped address resets and flags; data fetches do not.
// RULE18: Enabled low voltage flags, resets, holds pin until 4096 after recovery.
// RULE19: The stabilization counter is 12 bits and advances on oscillator falling edges.
// RULE20: Counter overflow is the clock pulse that advances the watchdog.
// RULE21: Stop clears the counter; wake delay is 32 or 4096 cycles by option.
// RULE22: After any reset the stabilization counter runs freely.
package rss_pkg;
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
   localparam logic [CNT_W-1:0] WAKE_SHORT_LAST = 12'h01f;
   localparam int SEQ_W = 6;
   localparam logic [SEQ_W-1:0] DRIVE_LAST = 6'h1f;
   localparam logic [SEQ_W-1:0] HOLD_LAST = 6'h1f;
   localparam int PIN_W = 13;
   localparam logic [PIN_W-1:0] PIN_SHORT = 13'h0043;
   localparam logic [PIN_W-1:0] PIN_MAX = 13'h1fff;
   localparam logic [15:0] VEC_NORM = 16'hfffe;
   localparam logic [15:0] VEC_MON = 16'hfefe;
   localparam logic [7:0] OPC_PRE = 8'h9e;
   localparam logic [7:0] OPC_STOP = 8'h8e;
   localparam int C_POR = 7;
   localparam int C_PIN = 6;
   localparam int C_WD = 5;
   localparam int C_OPC = 4;
   localparam int C_ADR = 3;
   localparam int C_LV = 1;
   localparam logic [7:0] CAUSE_POR_VAL = 8'h80;
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_PWR = 3'h1,
      ST_DRIVE = 3'h2,
      ST_HOLD = 3'h3,
      ST_EXT = 3'h4,
      ST_STOP = 3'h5,
      ST_WAKE = 3'h6
   } rss_st_e;
endpackage

// ==== rtl/rss_cnt_if.sv ====
// Interface between the sequencer and its stabilization counter.
`timescale 1ns/1ps
`default_nettype none
interface rss_cnt_if;
   logic tick;
   logic clr;
   logic [rss_pkg::CNT_W-1:0] value;
   logic ovf;
   modport ctrl (output tick, output clr, input value, input ovf);
   modport cnt (input tick, input clr, output value, output ovf);
endinterface
`default_nettype wire

// ==== rtl/rss_stab_counter.sv ====
// Twelve-bit stabilization counter with clear and overflow pulse.
`timescale 1ns/1ps
`default_nettype none
module rss_stab_counter
(
   input wire logic ref_clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   rss_cnt_if.cnt c // Counter controls and results.
);
   import rss_pkg::*;
   logic [CNT_W-1:0] val_q, val_d;
   logic ovf_q, ovf_d;

   // Clear wins; otherwise step once per oscillator falling edge.
   always_comb
   begin
      val_d = val_q;
      ovf_d = 1'b0;
      if (c.clr)
         val_d = '0; // RULE3
      else if (c.tick)
      begin
         val_d = val_q + 12'h001; // RULE19 RULE22
         ovf_d = (val_q == CNT_MAX); // RULE20
      end
   end

   // Counter registers.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         val_q <= '0;
         ovf_q <= 1'b0;
      end
      else
      begin
         val_q <= val_d;
         ovf_q <= ovf_d;
      end
   end

   assign c.value = val_q;
   assign c.ovf = ovf_q;

   AST_CNT_STEP: assert property (@(posedge ref_clk) disable iff (reset)
      (c.tick && !c.clr) |=> val_q == $past(val_q) + 12'h001) // RULE19
      else $error("Counter did not step on oscillator edge.");
endmodule
`default_nettype wire

// ==== rtl/rss_opcode_check.sv ====
// Opcode fetch checker for illegal opcodes, bad fetch addresses and stop.
`timescale 1ns/1ps
`default_nettype none
module rss_opcode_check
(
   input wire logic ref_clk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic flush, // Internal reset in progress.
   input wire logic op_fetch, // Opcode fetch strobe.
   input wire logic [7:0] op_byte, // Fetched opcode byte.
   input wire logic fetch_unmapped, // Fetch address is unmapped.
   input wire logic cpu_illegal, // CPU decode flags an illegal instruction.
   input wire logic stop_enable_opt, // Stop instruction allowed.
   output logic bad_opc, // Illegal opcode pulse.
   output logic bad_adr, // Unmapped opcode fetch pulse.
   output logic stop_go // Legal stop pulse.
);
   import rss_pkg::*;
   logic pre_q, pre_d, opc_q, opc_d, adr_q, adr_d, stp_q, stp_d;
   logic stop_fetch;

   // Classify each opcode fetch; data fetches are masked off by op_fetch.
   always_comb
   begin
      stop_fetch = op_fetch && !fetch_unmapped && (op_byte == OPC_STOP);
      opc_d = cpu_illegal || (stop_fetch && (pre_q || !stop_enable_opt)); // RULE14 RULE15 RULE16
      stp_d = stop_fetch && !pre_q && stop_enable_opt;
      adr_d = op_fetch && fetch_unmapped; // RULE17
      pre_d = op_fetch ? (op_byte == OPC_PRE) : pre_q;
      if (flush)
      begin
         opc_d = 1'b0;
         stp_d = 1'b0;
         adr_d = 1'b0;
         pre_d = 1'b0;
      end
   end

   // Checker registers.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pre_q <= 1'b0;
         opc_q <= 1'b0;
         adr_q <= 1'b0;
         stp_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         opc_q <= opc_d;
         adr_q <= adr_d;
         stp_q <= stp_d;
      end
   end

   assign bad_opc = opc_q;
   assign bad_adr = adr_q;
   assign stop_go = stp_q;
endmodule
`default_nettype wire

// ==== tb/rss_pin_partner.sv ====
// Reset line model: pull-up plus a peripheral that can pull the pin low.
`timescale 1ns/1ps
`default_nettype none
module rss_pin_partner
(
   input wire logic reset_pin_out, // Device drive value.
   input wire logic reset_pin_oe, // Device pulls the pin while high.
   input wire logic ext_pull, // Peripheral pulls the pin low.
   output logic pin_level // Resolved pin level.
);
   // Open drain line: the pull-up wins unless some party pulls it low.
   assign pin_level = ((reset_pin_oe && !reset_pin_out) || ext_pull) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== tb/tb_reset_source_sequencer.sv ====
// Self-checking bench for the reset source sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("Error at %0t: line %0d got %0h expected %0h", $time, `__LINE__, a, b); end end
module tb_reset_source_sequencer;
   import rss_pkg::*;
   logic ref_clk = 0, reset = 1, osc_ref_clock = 0, por_pulse = 0, ext_pull = 0;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, internal_reset_signal;
   logic watchdog_overflow = 0, watchdog_disable_opt = 0, low_voltage_det = 0;
   logic undervoltage_power_dis = 0, undervoltage_reset_dis = 0, op_fetch = 0;
   logic [7:0] op_byte = 8'h00;
   logic fetch_unmapped = 0, cpu_illegal = 0, stop_enable_opt = 0, short_wake_delay_opt = 0;
   logic wake_event = 0, monitor_mode = 0, core_source_clock_en, cpu_clock_en, watchdog_clk;
   logic [15:0] reset_vector;
   logic [7:0] reset_cause_register;
   int bad_count = 0, cmp_count = 0, ticks = 0, n;

   rss_reset_source_sequencer u_rss_reset_source_sequencer (.ref_clk, .reset, .osc_ref_clock,
      .por_pulse, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .watchdog_overflow,
      .watchdog_disable_opt, .low_voltage_det, .undervoltage_power_dis, .undervoltage_reset_dis,
      .op_fetch, .op_byte, .fetch_unmapped, .cpu_illegal, .stop_enable_opt, .short_wake_delay_opt,
      .wake_event, .monitor_mode, .internal_reset_signal, .reset_vector, .reset_cause_register,
      .core_source_clock_en, .cpu_clock_en, .watchdog_clk);
   rss_pin_partner u_rss_pin_partner (.reset_pin_out, .reset_pin_oe, .ext_pull,
      .pin_level(reset_pin_in));

   // System clock, oscillator at half its rate, and an oscillator tick count.
   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) osc_ref_clock <= #1 ~osc_ref_clock;
   always @(negedge osc_ref_clock) ticks++;

   // Steps k clock edges and lands just after the last one.
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   // Picks one watched output by number.
   function automatic logic sel(input int k);
      case (k)
         0: return reset_pin_oe;
         1: return internal_reset_signal;
         2: return cpu_clock_en;
         default: return watchdog_clk;
      endcase
   endfunction

   // Waits a bounded time for an output level and returns the ticks spent.
   task automatic wait_for(input int k, input logic v, input int lim, output int t);
      int t0;
      int c;
      t0 = ticks;
      c = 0;
      while (sel(k) !== v && c < lim)
      begin
         cyc(1);
         c++;
      end
      t = ticks - t0;
      `CHK(sel(k), v)
   endtask

   // Accepts a tick count within one tick of the expected figure.
   task automatic near(input int t, input int e);
      cmp_count++;
      if (t < e - 1 || t > e + 1)
      begin
         bad_count++;
         $display("Error at %0t: %0d ticks, expected %0d", $time, t, e);
      end
   endtask

   // Follows one reset: pin drive for a given span, then 32 ticks of hold.
   task automatic int_seq(input int first);
      wait_for(0, 1'b1, 20, n);
      `CHK(internal_reset_signal, 1'b1)
      `CHK(reset_pin_out, 1'b0)
      wait_for(0, 1'b0, 3 * first + 20, n);
      near(n, first);
      wait_for(1, 1'b0, 100, n);
      near(n, 32);
   endtask

   // One opcode fetch strobe.
   task automatic fetch(input logic [7:0] b, input logic u);
      op_fetch = 1'b1;
      op_byte = b;
      fetch_unmapped = u;
      cyc(1);
      op_fetch = 1'b0;
      fetch_unmapped = 1'b0;
      cyc(1);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Cuts a hang short well past the expected run length.
   initial
   begin
      repeat (90000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial
   begin
      cyc(8);
      `CHK(reset_cause_register, CAUSE_POR_VAL)
      `CHK(reset_vector, VEC_NORM)
      `CHK(internal_reset_signal, 1'b1)
      `CHK(core_source_clock_en, 1'b1)
      reset = 1'b0;
      cyc(4000);
      `CHK(cpu_clock_en, 1'b0)
      `CHK(reset_pin_oe, 1'b1)
      int_seq(2128);
      wait_for(3, 1'b1, 9000, n);
      cyc(1);
      wait_for(3, 1'b1, 9000, n);
      near(n, 4096);
      fetch_unmapped = 1'b1;
      cyc(4);
      fetch_unmapped = 1'b0;
      `CHK(internal_reset_signal, 1'b0)
      fetch(8'h00, 1'b1);
      int_seq(32);
      `CHK(reset_cause_register[C_ADR], 1'b1)
      ext_pull = 1'b1;
      cyc(10);
      `CHK(internal_reset_signal, 1'b1)
      cyc(110);
      ext_pull = 1'b0;
      wait_for(1, 1'b0, 100, n);
      `CHK(reset_cause_register[C_PIN], 1'b0)
      ext_pull = 1'b1;
      cyc(140);
      ext_pull = 1'b0;
      wait_for(1, 1'b0, 100, n);
      near(n, 32);
      `CHK(reset_cause_register[C_PIN], 1'b1)
      monitor_mode = 1'b1;
      cpu_illegal = 1'b1;
      cyc(1);
      cpu_illegal = 1'b0;
      int_seq(32);
      `CHK(reset_cause_register[C_OPC], 1'b1)
      `CHK(reset_vector, VEC_MON)
      fetch(OPC_STOP, 1'b0);
      int_seq(32);
      stop_enable_opt = 1'b1;
      fetch(OPC_PRE, 1'b0);
      fetch(OPC_STOP, 1'b0);
      int_seq(32);
      monitor_mode = 1'b0;
      watchdog_disable_opt = 1'b1;
      watchdog_overflow = 1'b1;
      cyc(2);
      watchdog_overflow = 1'b0;
      cyc(10);
      `CHK(internal_reset_signal, 1'b0)
      watchdog_disable_opt = 1'b0;
      watchdog_overflow = 1'b1;
      cyc(2);
      watchdog_overflow = 1'b0;
      int_seq(32);
      `CHK(reset_cause_register[C_WD], 1'b1)
      `CHK(reset_vector, VEC_NORM)
      short_wake_delay_opt = 1'b1;
      fetch(OPC_STOP, 1'b0);
      `CHK(core_source_clock_en, 1'b0)
      `CHK(cpu_clock_en, 1'b0)
      wake_event = 1'b1;
      cyc(1);
      wake_event = 1'b0;
      wait_for(2, 1'b1, 200, n);
      near(n, 32);
      short_wake_delay_opt = 1'b0;
      fetch(OPC_STOP, 1'b0);
      wake_event = 1'b1;
      cyc(1);
      wake_event = 1'b0;
      wait_for(2, 1'b1, 9000, n);
      near(n, 4096);
      undervoltage_power_dis = 1'b1;
      low_voltage_det = 1'b1;
      cyc(10);
      `CHK(internal_reset_signal, 1'b0)
      undervoltage_power_dis = 1'b0;
      undervoltage_reset_dis = 1'b1;
      cyc(10);
      `CHK(internal_reset_signal, 1'b0)
      undervoltage_reset_dis = 1'b0;
      cyc(4);
      `CHK(reset_cause_register[C_LV], 1'b1)
      low_voltage_det = 1'b0;
      int_seq(4128);
      por_pulse = 1'b1;
      cyc(1);
      por_pulse = 1'b0;
      cyc(2);
      `CHK(reset_cause_register, CAUSE_POR_VAL)
      int_seq(4128);
      `CHK(reset_cause_register[C_PIN], 1'b0)
      give_verdict();
   end
endmodule
`default_nettype wire
